//--- logic/soft_reset_pkg.sv
// Package: register map, field positions and bus carriers for the soft reset block.
// Assumes a 32-bit classic Wishbone slave on one clock.
`default_nettype none
package soft_reset_pkg;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [11:0] WATCHDOG_SOFT_RESET_OFFSET = 12'h040;
    localparam logic [11:0] SERIAL_TIMER_COMPARATOR_SOFT_RESET_OFFSET = 12'h044;
    localparam logic [11:0] PORT_SOFT_RESET_OFFSET = 12'h048;
    localparam logic [11:0] CAPABILITY_MASK_FIRST_OFFSET = 12'h050;
    localparam logic [11:0] CAPABILITY_MASK_SECOND_OFFSET = 12'h054;
    localparam logic [11:0] CAPABILITY_MASK_FOURTH_OFFSET = 12'h058;

    // ----------------------------------------
    // Values after reset
    // ----------------------------------------
    localparam logic [31:0] SOFT_RESET_RESET_VALUE = 32'h0000_0000;
    localparam logic [31:0] CAPABILITY_RESET_VALUE = 32'hFFFF_FFFF;

    // ----------------------------------------
    // Implemented (writable) bits per register
    // ----------------------------------------
    localparam logic [31:0] WATCHDOG_FIELD_MASK = 32'h0000_0008;
    localparam logic [31:0] SERIAL_FIELD_MASK = 32'h0707_1013;
    localparam logic [31:0] PORT_FIELD_MASK = 32'h0000_001F;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int WATCHDOG_RESET_BIT_POS = 3;
    localparam int COMPARATOR_ZERO_POS = 24;
    localparam int GP_COUNTER_ZERO_POS = 16;
    localparam int TWO_WIRE_ZERO_POS = 12;
    localparam int SYNC_SERIAL_ZERO_POS = 4;
    localparam int ASYNC_SERIAL_ZERO_POS = 0;
    localparam int ASYNC_SERIAL_ONE_POS = 1;
    localparam int PORT_A_POS = 0;
    localparam int UNIT_GROUP = 3;
    localparam int PORT_COUNT = 5;
    localparam int SYNC_STAGES = 3;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic watchdog_reset_bit;
        logic [2:0] comparator_reset;
        logic [2:0] gp_counter_reset;
        logic two_wire_unit_zero_reset;
        logic sync_serial_zero_reset;
        logic async_serial_zero_reset;
        logic async_serial_one_reset;
        logic [4:0] port_reset;
    } unit_resets_t;

endpackage : soft_reset_pkg
`default_nettype wire

//--- logic/masked_word_reg.sv
// Holds one 32-bit word written by byte lanes, masked by a per-bit write enable.
// Assumes the caller qualifies the write strobe with the bus handshake.
`timescale 1ns/1ps
`default_nettype none
module masked_word_reg
#(
    parameter logic [31:0] RESET_VALUE = 32'h0000_0000
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic write,
    input wire logic [3:0] sel,
    input wire logic [31:0] wdata,
    input wire logic [31:0] bit_enable,
    output logic [31:0] value
);

    logic [31:0] lane_mask;

    // ----------------------------------------
    // Byte lane expansion
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_lane
            assign lane_mask[8*i +: 8] = {8{sel[i]}};
        end
    endgenerate

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            value <= RESET_VALUE;
        else if (ce && write)
            value <= (value & ~(lane_mask & bit_enable)) | (wdata & lane_mask & bit_enable);
    end

endmodule : masked_word_reg
`default_nettype wire

//--- logic/level_sync.sv
// Three-stage synchroniser; output changes once stages two and three agree.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module level_sync
#(
    parameter int STAGES = 3
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic async_in,
    output logic sync_out
);

    logic [STAGES-1:0] chain;

    generate
        if (STAGES != 3)
        begin : g_bad_stages
            $error("level_sync supports exactly three stages");
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            chain <= '0;
        else if (ce)
            chain <= {chain[STAGES-2:0], async_in};
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            sync_out <= 1'b0;
        else if (ce && (chain[1] == chain[2]))
            sync_out <= chain[2];
    end

endmodule : level_sync
`default_nettype wire

//--- logic/peripheral_soft_reset_control.sv
// Software reset control for on-chip peripherals, reached over classic Wishbone.
// Assumes one clock, clk at 10 MHz, and an asynchronous active-low nrst.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module peripheral_soft_reset_control
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic test_hold_all,
    output logic watchdog_reset_bit,
    output logic comparator_zero_reset,
    output logic comparator_one_reset,
    output logic comparator_two_reset,
    output logic gp_counter_zero_reset,
    output logic gp_counter_one_reset,
    output logic gp_counter_two_reset,
    output logic two_wire_unit_zero_reset,
    output logic sync_serial_zero_reset,
    output logic async_serial_zero_reset,
    output logic async_serial_one_reset,
    output logic port_a_reset,
    output logic port_b_reset,
    output logic port_c_reset,
    output logic port_d_reset,
    output logic port_e_reset
);

    // ----------------------------------------
    // Bus request and decode
    // ----------------------------------------
    soft_reset_pkg::wb_req_t req;
    soft_reset_pkg::unit_resets_t next_resets;
    logic access;
    logic mapped;
    logic write_now;
    logic [31:0] next_rdata;
    logic [31:0] watchdog_soft_reset;
    logic [31:0] serial_timer_comparator_soft_reset;
    logic [31:0] port_soft_reset;
    logic [31:0] capability_mask_first;
    logic [31:0] capability_mask_second;
    logic [31:0] capability_mask_fourth;
    logic hold_all;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

    function automatic logic hit(input logic [11:0] adr, input logic [11:0] offset);
        hit = (adr[11:2] == offset[11:2]);
    endfunction : hit

    assign access = req.cyc && req.stb && !wb_ack_o && !wb_err_o;
    assign mapped = hit(req.adr, soft_reset_pkg::WATCHDOG_SOFT_RESET_OFFSET)
        || hit(req.adr, soft_reset_pkg::SERIAL_TIMER_COMPARATOR_SOFT_RESET_OFFSET)
        || hit(req.adr, soft_reset_pkg::PORT_SOFT_RESET_OFFSET)
        || hit(req.adr, soft_reset_pkg::CAPABILITY_MASK_FIRST_OFFSET)
        || hit(req.adr, soft_reset_pkg::CAPABILITY_MASK_SECOND_OFFSET)
        || hit(req.adr, soft_reset_pkg::CAPABILITY_MASK_FOURTH_OFFSET);
    assign write_now = access && req.we;

    // ----------------------------------------
    // Capability masks
    // ----------------------------------------
    masked_word_reg #(.RESET_VALUE(soft_reset_pkg::CAPABILITY_RESET_VALUE)) u_cap_first
    (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .write(write_now && hit(req.adr, soft_reset_pkg::CAPABILITY_MASK_FIRST_OFFSET)),
        .sel(req.sel),
        .wdata(req.dat),
        .bit_enable(32'hFFFF_FFFF),
        .value(capability_mask_first)
    );

    masked_word_reg #(.RESET_VALUE(soft_reset_pkg::CAPABILITY_RESET_VALUE)) u_cap_second
    (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .write(write_now && hit(req.adr, soft_reset_pkg::CAPABILITY_MASK_SECOND_OFFSET)),
        .sel(req.sel),
        .wdata(req.dat),
        .bit_enable(32'hFFFF_FFFF),
        .value(capability_mask_second)
    );

    masked_word_reg #(.RESET_VALUE(soft_reset_pkg::CAPABILITY_RESET_VALUE)) u_cap_fourth
    (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .write(write_now && hit(req.adr, soft_reset_pkg::CAPABILITY_MASK_FOURTH_OFFSET)),
        .sel(req.sel),
        .wdata(req.dat),
        .bit_enable(32'hFFFF_FFFF),
        .value(capability_mask_fourth)
    );

    // ----------------------------------------
    // Reset-control registers
    // ----------------------------------------
    masked_word_reg #(.RESET_VALUE(soft_reset_pkg::SOFT_RESET_RESET_VALUE)) u_watchdog
    (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .write(write_now && hit(req.adr, soft_reset_pkg::WATCHDOG_SOFT_RESET_OFFSET)),
        .sel(req.sel),
        .wdata(req.dat),
        .bit_enable(capability_mask_first & soft_reset_pkg::WATCHDOG_FIELD_MASK),
        .value(watchdog_soft_reset)
    );

    masked_word_reg #(.RESET_VALUE(soft_reset_pkg::SOFT_RESET_RESET_VALUE)) u_serial
    (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .write(write_now && hit(req.adr, soft_reset_pkg::SERIAL_TIMER_COMPARATOR_SOFT_RESET_OFFSET)),
        .sel(req.sel),
        .wdata(req.dat),
        .bit_enable(capability_mask_second & soft_reset_pkg::SERIAL_FIELD_MASK),
        .value(serial_timer_comparator_soft_reset)
    );

    masked_word_reg #(.RESET_VALUE(soft_reset_pkg::SOFT_RESET_RESET_VALUE)) u_port
    (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .write(write_now && hit(req.adr, soft_reset_pkg::PORT_SOFT_RESET_OFFSET)),
        .sel(req.sel),
        .wdata(req.dat),
        .bit_enable(capability_mask_fourth & soft_reset_pkg::PORT_FIELD_MASK),
        .value(port_soft_reset)
    );

    // ----------------------------------------
    // Test hold pin
    // ----------------------------------------
    level_sync #(.STAGES(soft_reset_pkg::SYNC_STAGES)) u_hold_sync
    (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .async_in(test_hold_all),
        .sync_out(hold_all)
    );

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (hit(req.adr, soft_reset_pkg::WATCHDOG_SOFT_RESET_OFFSET))
            next_rdata = watchdog_soft_reset;
        else if (hit(req.adr, soft_reset_pkg::SERIAL_TIMER_COMPARATOR_SOFT_RESET_OFFSET))
            next_rdata = serial_timer_comparator_soft_reset;
        else if (hit(req.adr, soft_reset_pkg::PORT_SOFT_RESET_OFFSET))
            next_rdata = port_soft_reset;
        else if (hit(req.adr, soft_reset_pkg::CAPABILITY_MASK_FIRST_OFFSET))
            next_rdata = capability_mask_first;
        else if (hit(req.adr, soft_reset_pkg::CAPABILITY_MASK_SECOND_OFFSET))
            next_rdata = capability_mask_second;
        else if (hit(req.adr, soft_reset_pkg::CAPABILITY_MASK_FOURTH_OFFSET))
            next_rdata = capability_mask_fourth;
    end

    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else if (ce)
        begin
            wb_ack_o <= access && mapped;
            wb_err_o <= access && !mapped;
            wb_dat_o <= (access && !req.we) ? next_rdata : 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Peripheral reset outputs
    // ----------------------------------------
    always_comb
    begin
        next_resets.watchdog_reset_bit = watchdog_soft_reset[soft_reset_pkg::WATCHDOG_RESET_BIT_POS];
        next_resets.comparator_reset =
            serial_timer_comparator_soft_reset[soft_reset_pkg::COMPARATOR_ZERO_POS +: soft_reset_pkg::UNIT_GROUP];
        next_resets.gp_counter_reset =
            serial_timer_comparator_soft_reset[soft_reset_pkg::GP_COUNTER_ZERO_POS +: soft_reset_pkg::UNIT_GROUP];
        next_resets.two_wire_unit_zero_reset =
            serial_timer_comparator_soft_reset[soft_reset_pkg::TWO_WIRE_ZERO_POS];
        next_resets.sync_serial_zero_reset =
            serial_timer_comparator_soft_reset[soft_reset_pkg::SYNC_SERIAL_ZERO_POS];
        next_resets.async_serial_zero_reset =
            serial_timer_comparator_soft_reset[soft_reset_pkg::ASYNC_SERIAL_ZERO_POS];
        next_resets.async_serial_one_reset =
            serial_timer_comparator_soft_reset[soft_reset_pkg::ASYNC_SERIAL_ONE_POS];
        next_resets.port_reset = port_soft_reset[soft_reset_pkg::PORT_A_POS +: soft_reset_pkg::PORT_COUNT];
        if (hold_all)
            next_resets = '1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            watchdog_reset_bit <= 1'b0;
            {comparator_two_reset, comparator_one_reset, comparator_zero_reset} <= 3'h0;
            {gp_counter_two_reset, gp_counter_one_reset, gp_counter_zero_reset} <= 3'h0;
            two_wire_unit_zero_reset <= 1'b0;
            sync_serial_zero_reset <= 1'b0;
            async_serial_zero_reset <= 1'b0;
            async_serial_one_reset <= 1'b0;
            {port_e_reset, port_d_reset, port_c_reset, port_b_reset, port_a_reset} <= 5'h00;
        end
        else if (ce)
        begin
            watchdog_reset_bit <= next_resets.watchdog_reset_bit;
            {comparator_two_reset, comparator_one_reset, comparator_zero_reset} <= next_resets.comparator_reset;
            {gp_counter_two_reset, gp_counter_one_reset, gp_counter_zero_reset} <= next_resets.gp_counter_reset;
            two_wire_unit_zero_reset <= next_resets.two_wire_unit_zero_reset;
            sync_serial_zero_reset <= next_resets.sync_serial_zero_reset;
            async_serial_zero_reset <= next_resets.async_serial_zero_reset;
            async_serial_one_reset <= next_resets.async_serial_one_reset;
            {port_e_reset, port_d_reset, port_c_reset, port_b_reset, port_a_reset} <= next_resets.port_reset;
        end
    end

endmodule : peripheral_soft_reset_control
`default_nettype wire

//--- testbench/psrc_checker_assertions.sv
// Checker: bus answers and the causes of reset-output changes.
// Assumes a bind into the top module; the bench makes no request while ce is low.
`timescale 1ns/1ps
`default_nettype none
module psrc_checker
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic test_hold_all,
    input wire logic watchdog_reset_bit,
    input wire logic comparator_zero_reset,
    input wire logic comparator_one_reset,
    input wire logic comparator_two_reset,
    input wire logic gp_counter_zero_reset,
    input wire logic gp_counter_one_reset,
    input wire logic gp_counter_two_reset,
    input wire logic two_wire_unit_zero_reset,
    input wire logic sync_serial_zero_reset,
    input wire logic async_serial_zero_reset,
    input wire logic async_serial_one_reset,
    input wire logic port_a_reset,
    input wire logic port_b_reset,
    input wire logic port_c_reset,
    input wire logic port_d_reset,
    input wire logic port_e_reset
);
    wire logic take = ce && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire logic [9:0] word = wb_adr_i[11:2];
    wire logic mapped = word inside {10'h010, 10'h011, 10'h012, 10'h014, 10'h015, 10'h016};
    wire logic wr_wd = take && wb_we_i && word == 10'h010;
    wire logic wr_ser = take && wb_we_i && word == 10'h011;
    wire logic wr_port = take && wb_we_i && word == 10'h012;
    wire logic [9:0] ser = {comparator_two_reset, comparator_one_reset, comparator_zero_reset,
        gp_counter_two_reset, gp_counter_one_reset, gp_counter_zero_reset, two_wire_unit_zero_reset,
        sync_serial_zero_reset, async_serial_one_reset, async_serial_zero_reset};
    wire logic [4:0] ports = {port_e_reset, port_d_reset, port_c_reset, port_b_reset, port_a_reset};
    logic [31:0] rmask;
    logic [2:0] quiet;
    // Reserved positions of the word being read
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rmask <= 32'h0;
        else if (take && !wb_we_i)
            rmask <= word == 10'h010 ? ~soft_reset_pkg::WATCHDOG_FIELD_MASK
                : word == 10'h011 ? ~soft_reset_pkg::SERIAL_FIELD_MASK
                : word == 10'h012 ? ~soft_reset_pkg::PORT_FIELD_MASK : 32'h0;
        else
            rmask <= 32'h0;
    end
    // Cycles since the hold pin was last high
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            quiet <= 3'h0;
        else if (test_hold_all)
            quiet <= 3'h0;
        else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence s_take;
        take;
    endsequence
    sequence s_answer;
        ##1 (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
    endsequence
    answer_pulse_a: assert property (s_take |-> s_answer)
        else $error("request not answered by a one-cycle pulse");
    unmapped_err_a: assert property (take && !mapped |=> wb_err_o && wb_dat_o == 32'h0)
        else $error("unmapped access not refused");
    mapped_ack_a: assert property (take && mapped |=> wb_ack_o)
        else $error("mapped access not acknowledged");
    idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside an ack cycle");
    reserved_zero_a: assert property (wb_ack_o |-> (wb_dat_o & rmask) == 32'h0)
        else $error("reserved bit read as one");
    watchdog_cause_a: assert property (quiet == 3'h7 && $changed(watchdog_reset_bit) |-> $past(wr_wd, 2))
        else $error("watchdog reset moved without a write");
    serial_cause_a: assert property (quiet == 3'h7 && $changed(ser) |-> $past(wr_ser, 2))
        else $error("serial reset moved without a write");
    port_cause_a: assert property (quiet == 3'h7 && $changed(ports) |-> $past(wr_port, 2))
        else $error("port reset moved without a write");
    reset_clear_a: assert property ($rose(nrst) |-> {ser, ports, watchdog_reset_bit} == 16'h0)
        else $error("reset outputs not clear after reset");
endmodule : psrc_checker
bind peripheral_soft_reset_control psrc_checker psrc_checker_inst (.*);
`default_nettype wire

//--- testbench/tb.sv
// Testbench: corner and random register traffic for the soft reset block.
// Assumes the design and its checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, nrst, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, test_hold_all, rd_err;
    logic [3:0] wb_sel_i;
    logic [11:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd_data, lfsr_state;
    logic watchdog_reset_bit, comparator_zero_reset, comparator_one_reset, comparator_two_reset;
    logic gp_counter_zero_reset, gp_counter_one_reset, gp_counter_two_reset, two_wire_unit_zero_reset;
    logic sync_serial_zero_reset, async_serial_zero_reset, async_serial_one_reset;
    logic port_a_reset, port_b_reset, port_c_reset, port_d_reset, port_e_reset;
    logic [31:0] regs [6];
    int n_fail, check_count;
    localparam logic [11:0] ADR [8] = '{12'h040, 12'h044, 12'h048, 12'h050, 12'h054, 12'h058, 12'h04C, 12'h100};
    localparam logic [31:0] FMASK [3] = '{soft_reset_pkg::WATCHDOG_FIELD_MASK,
        soft_reset_pkg::SERIAL_FIELD_MASK, soft_reset_pkg::PORT_FIELD_MASK};
    wire logic [15:0] units = {port_e_reset, port_d_reset, port_c_reset, port_b_reset, port_a_reset,
        async_serial_one_reset, async_serial_zero_reset, sync_serial_zero_reset, two_wire_unit_zero_reset,
        gp_counter_two_reset, gp_counter_one_reset, gp_counter_zero_reset, comparator_two_reset,
        comparator_one_reset, comparator_zero_reset, watchdog_reset_bit};
    peripheral_soft_reset_control peripheral_soft_reset_control_inst
    (
        .clk(clk), .nrst(nrst), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .test_hold_all(test_hold_all),
        .watchdog_reset_bit(watchdog_reset_bit), .comparator_zero_reset(comparator_zero_reset),
        .comparator_one_reset(comparator_one_reset), .comparator_two_reset(comparator_two_reset),
        .gp_counter_zero_reset(gp_counter_zero_reset), .gp_counter_one_reset(gp_counter_one_reset),
        .gp_counter_two_reset(gp_counter_two_reset), .two_wire_unit_zero_reset(two_wire_unit_zero_reset),
        .sync_serial_zero_reset(sync_serial_zero_reset), .async_serial_zero_reset(async_serial_zero_reset),
        .async_serial_one_reset(async_serial_one_reset), .port_a_reset(port_a_reset),
        .port_b_reset(port_b_reset), .port_c_reset(port_c_reset), .port_d_reset(port_d_reset),
        .port_e_reset(port_e_reset)
    );
    // ----------------------------------------
    // Expectations and bus cycles
    // ----------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
        input logic [3:0] s, input int r);
        logic [31:0] wm;
        wm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        if (r < 3)
            wm = wm & FMASK[r] & regs[r + 3];
        return (old & ~wm) | (d & wm);
    endfunction : merge
    function automatic logic [15:0] exp_units();
        return {regs[2][4:0], regs[1][1:0], regs[1][4], regs[1][12], regs[1][18:16], regs[1][26:24], regs[0][3]};
    endfunction : exp_units
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        @(posedge clk);
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        cmp(32'(n < 20), 32'h1);
        rd_data = wb_dat_o;
        rd_err = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : bus
    task automatic op(input int r, input logic we, input logic [31:0] d, input logic [3:0] s);
        bus(we, ADR[r], d, s);
        cmp(32'(rd_err), 32'(r > 5));
        if (we && r < 6)
            regs[r] = merge(regs[r], d, s, r);
        if (!we)
            cmp(rd_data, r < 6 ? regs[r] : 32'h0);
        @(posedge clk);
        #1 cmp(32'(units), 32'(exp_units()));
    endtask : op
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    // ----------------------------------------
    // Clock, watchdog and sequence
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        #2000000;
        n_fail++;
        complete_run();
    end
    initial
    begin
        {nrst, wb_cyc_i, wb_stb_i, wb_we_i, test_hold_all, wb_sel_i, wb_adr_i, wb_dat_i} = '0;
        ce = 1'b1;
        lfsr_state = 32'hDAC2;
        foreach (regs[i])
            regs[i] = i < 3 ? 32'h0 : 32'hFFFF_FFFF;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 8; i++)
            op(i, 1'b0, 32'h0, 4'h0);
        op(7, 1'b1, 32'hFFFF_FFFF, 4'hF);
        for (int i = 0; i < 3; i++)
            op(i, 1'b1, 32'hFFFF_FFFF, 4'hF);
        for (int i = 0; i < 3; i++)
            op(i, 1'b0, 32'h0, 4'h0);
        for (int i = 0; i < 6; i++)
            op(i, 1'b1, 32'h0, 4'hF);
        for (int i = 0; i < 3; i++)
            op(i, 1'b1, 32'hFFFF_FFFF, 4'hF);
        for (int i = 0; i < 200; i++)
        begin
            lfsr_state = lfsr_next(lfsr_state);
            op(int'(lfsr_state[2:0]), lfsr_state[8], lfsr_next(lfsr_state), lfsr_state[7:4]);
            op(int'(lfsr_state[2:0]), 1'b0, 32'h0, 4'h0);
        end
        @(posedge clk);
        test_hold_all <= 1'b1;
        repeat (8) @(posedge clk);
        #1 cmp(32'(units), 32'h0000_FFFF);
        @(posedge clk);
        test_hold_all <= 1'b0;
        repeat (8) @(posedge clk);
        #1 cmp(32'(units), 32'(exp_units()));
        // Frozen while ce is low: the hold pin must not get through
        @(posedge clk);
        ce <= 1'b0;
        test_hold_all <= 1'b1;
        repeat (8) @(posedge clk);
        #1 cmp(32'(units), 32'(exp_units()));
        @(posedge clk);
        test_hold_all <= 1'b0;
        ce <= 1'b1;
        repeat (8) @(posedge clk);
        #1 cmp(32'(units), 32'(exp_units()));
        // Mid-run reset with every unit held
        for (int i = 5; i >= 0; i--)
            op(i, 1'b1, 32'hFFFF_FFFF, 4'hF);
        @(posedge clk);
        nrst <= 1'b0;
        foreach (regs[i])
            regs[i] = i < 3 ? 32'h0 : 32'hFFFF_FFFF;
        repeat (2) @(posedge clk);
        #1 cmp(32'(units), 32'h0);
        @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 6; i++)
            op(i, 1'b0, 32'h0, 4'h0);
        complete_run();
    end
endmodule : tb
`default_nettype wire
